// File: pkg/rslsi_pkg.sv
package rslsi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte addresses.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_EVENT = 8'h08;
    localparam logic [7:0] REG_PULSE = 8'h0C;

    // Write and read responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Status register field positions.
    localparam int ST_VALID = 0;
    localparam int ST_IN_RESET = 1;
    localparam int ST_PICK0 = 2;
    localparam int ST_PICK1 = 3;
    localparam int ST_CODE_LO = 4;
    localparam int ST_COMPOUND = 6;
    localparam int ST_MASK_LO = 8;
    localparam int ST_HS_LOW = 12;
    localparam int ST_SUSP_LOW = 13;

    // Control register fields and reset value.
    localparam int CTRL_W = 3;
    localparam int CT_HS_EN = 0;
    localparam int CT_SUSP_EN = 1;
    localparam int CT_FIXED_EN = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;

    // Event register fields (write one to clear).
    localparam int EVT_W = 2;
    localparam int EV_SHORT = 0;
    localparam int EV_RELEASE = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Hub shape and strap code width.
    localparam int DS_PORTS = 4;
    localparam int CODE_W = 2;

    // Timing: least low time of the hub reset input.
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 1000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    // Phase of the hub reset input.
    typedef enum logic [0:0]
    {
        PH_HELD = 1'b0,
        PH_RUN = 1'b1
    } rslsi_phase_t;

endpackage

// File: pkg/rslsi_bus_if.sv
interface rslsi_bus_if;
    // Write strobe with its address, data and byte lanes.
    logic wr_en;
    logic [rslsi_pkg::ADDR_W-1:0] wr_addr;
    logic [rslsi_pkg::DATA_W-1:0] wr_data;
    logic [rslsi_pkg::STRB_W-1:0] wr_strb;
    logic wr_ok;
    // Read address and combinational answer.
    logic [rslsi_pkg::ADDR_W-1:0] rd_addr;
    logic [rslsi_pkg::DATA_W-1:0] rd_data;
    logic rd_ok;

    modport slave_side (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_strb,
        input wr_ok,
        output rd_addr,
        input rd_data,
        input rd_ok
    );

    modport regs_side (
        input wr_en,
        input wr_addr,
        input wr_data,
        input wr_strb,
        output wr_ok,
        input rd_addr,
        output rd_data,
        output rd_ok
    );
endinterface

// File: design/rslsi_axil_slave.sv
module rslsi_axil_slave (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Write address channel.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rslsi_pkg::ADDR_W-1:0] s_axi_awaddr,
    // Write data channel.
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [rslsi_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [rslsi_pkg::STRB_W-1:0] s_axi_wstrb,
    // Write response channel.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address channel.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rslsi_pkg::ADDR_W-1:0] s_axi_araddr,
    // Read data channel.
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [rslsi_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Register side.
    rslsi_bus_if.slave_side bus
);

    typedef struct packed {
        logic aw_v;
        logic [rslsi_pkg::ADDR_W-1:0] aw_a;
        logic w_v;
        logic [rslsi_pkg::DATA_W-1:0] w_d;
        logic [rslsi_pkg::STRB_W-1:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [rslsi_pkg::DATA_W-1:0] r_d;
        logic [1:0] r_r;
    } rslsi_axs_t;

    rslsi_axs_t st_r;
    rslsi_axs_t st_nxt;
    logic commit;

    // Address and data wait apart until both are in, either first.
    // A new write waits for the previous response.
    assign s_axi_awready = !st_r.aw_v && !st_r.b_v;
    assign s_axi_wready = !st_r.w_v && !st_r.b_v;
    assign s_axi_arready = !st_r.r_v;
    assign commit = st_r.aw_v && st_r.w_v && !st_r.b_v;

    // Register strobe and read lookup.
    assign bus.wr_en = commit;
    assign bus.wr_addr = st_r.aw_a;
    assign bus.wr_data = st_r.w_d;
    assign bus.wr_strb = st_r.w_s;
    assign bus.rd_addr = s_axi_araddr;

    // Responses come straight from the state.
    assign s_axi_bvalid = st_r.b_v;
    assign s_axi_bresp = st_r.b_r;
    assign s_axi_rvalid = st_r.r_v;
    assign s_axi_rdata = st_r.r_d;
    assign s_axi_rresp = st_r.r_r;

    // Channel bookkeeping.
    always_comb
    begin
        st_nxt = st_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_v = 1'b1;
            st_nxt.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_v = 1'b1;
            st_nxt.w_d = s_axi_wdata;
            st_nxt.w_s = s_axi_wstrb;
        end
        if (commit)
        begin
            st_nxt.aw_v = 1'b0;
            st_nxt.w_v = 1'b0;
            st_nxt.b_v = 1'b1;
            st_nxt.b_r = bus.wr_ok ? rslsi_pkg::RESP_OKAY : rslsi_pkg::RESP_SLVERR;
        end
        else if (st_r.b_v && s_axi_bready)
        begin
            st_nxt.b_v = 1'b0;
        end
        // Unmapped reads answer zero with an error.
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.r_v = 1'b1;
            st_nxt.r_d = bus.rd_ok ? bus.rd_data : 32'h0000_0000;
            st_nxt.r_r = bus.rd_ok ? rslsi_pkg::RESP_OKAY : rslsi_pkg::RESP_SLVERR;
        end
        else if (st_r.r_v && s_axi_rready)
        begin
            st_nxt.r_v = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// File: design/rslsi_top.sv
// Overview of operation
// - Latch first configuration pick at reset release.
// - Latch second configuration pick at same release.
// - Sample both fixed-port straps when function enabled.
// - Decode code into fixed ports one to three.
// - Any fixed port makes the hub compound.
// - High-speed lamp on at high speed, off otherwise.
// - Shared lamp polarity follows its own strap value.
// - Low-strap lamp active high for 00, 10.
module rslsi_top (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Register bus.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rslsi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [rslsi_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [rslsi_pkg::STRB_W-1:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rslsi_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [rslsi_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Hub reset pin and strap pins.
    input wire logic hub_reset_n,
    input wire logic config_pick_0_in,
    input wire logic fixed_port_strap_hi_in,
    // Shared high-speed lamp and second configuration pick pin.
    input wire logic high_speed_lamp_in,
    output logic high_speed_lamp_out,
    output logic high_speed_lamp_oe,
    // Shared suspend lamp and low fixed-port strap pin.
    input wire logic suspend_lamp_in,
    output logic suspend_lamp_out,
    output logic suspend_lamp_oe,
    // Hub core state.
    input wire logic hs_connected,
    input wire logic hub_active,
    // Captured configuration for the hub core.
    output logic hub_in_reset,
    output logic straps_valid,
    output logic [1:0] config_method,
    output logic [rslsi_pkg::CODE_W-1:0] fixed_port_code,
    output logic [rslsi_pkg::DS_PORTS-1:0] fixed_port_mask,
    output logic compound_dev
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        rslsi_pkg::rslsi_phase_t phase;
        logic valid;
        logic pick0;
        logic pick1;
        logic [rslsi_pkg::CODE_W-1:0] code;
        logic [rslsi_pkg::DS_PORTS-1:0] mask;
        logic compound;
        logic hs_low;
        logic susp_low;
        logic [rslsi_pkg::CNT_W-1:0] low_cnt;
        logic [rslsi_pkg::CNT_W-1:0] last_low;
        logic [rslsi_pkg::CTRL_W-1:0] ctrl;
        logic [rslsi_pkg::EVT_W-1:0] evt;
        logic hs_o;
        logic hs_oe;
        logic susp_o;
        logic susp_oe;
    } rslsi_state_t;

    localparam logic [rslsi_pkg::CNT_W-1:0] MIN_LOW =
        rslsi_pkg::CNT_W'(rslsi_pkg::RESET_MIN_CYC);

    rslsi_state_t st_r;
    rslsi_state_t st_nxt;
    rslsi_bus_if bus ();

    logic [rslsi_pkg::CODE_W-1:0] cap_code;
    logic [rslsi_pkg::DS_PORTS-1:0] cap_mask;
    logic [rslsi_pkg::EVT_W-1:0] evt_set;
    logic [rslsi_pkg::EVT_W-1:0] evt_clr;
    logic wr_ctrl;
    logic wr_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    rslsi_axil_slave u_slave (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .bus(bus.slave_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Strap decode at the capture point.

    // gated fixed-port sample
    // Sampled only when enabled; otherwise all ports removable.
    assign cap_code = st_r.ctrl[rslsi_pkg::CT_FIXED_EN] ?
        {fixed_port_strap_hi_in, suspend_lamp_in} : '0;

    // code to port mask
    // Port n+1 is fixed when n is below the code; ports beyond three never are.
    for (genvar gi = 0; gi < rslsi_pkg::DS_PORTS; gi++)
    begin : g_mask
        assign cap_mask[gi] = (rslsi_pkg::CODE_W'(gi) < cap_code) && (gi < 3);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.

    // Only control and event take writes; status and pulse writes are dropped with OKAY, unmapped ones get an error.
    assign wr_ctrl = bus.wr_en && (bus.wr_addr == rslsi_pkg::REG_CTRL) && bus.wr_strb[0];
    assign wr_evt = bus.wr_en && (bus.wr_addr == rslsi_pkg::REG_EVENT) && bus.wr_strb[0];
    assign bus.wr_ok = (bus.wr_addr == rslsi_pkg::REG_STATUS)
        || (bus.wr_addr == rslsi_pkg::REG_CTRL)
        || (bus.wr_addr == rslsi_pkg::REG_EVENT)
        || (bus.wr_addr == rslsi_pkg::REG_PULSE);
    assign evt_clr = wr_evt ? bus.wr_data[rslsi_pkg::EVT_W-1:0] : '0;

    // Read mux; unused bits read as zero.
    always_comb
    begin
        bus.rd_data = 32'h0000_0000;
        bus.rd_ok = 1'b1;
        unique case (bus.rd_addr)
            rslsi_pkg::REG_STATUS:
            begin
                bus.rd_data[rslsi_pkg::ST_VALID] = st_r.valid;
                bus.rd_data[rslsi_pkg::ST_IN_RESET] = (st_r.phase == rslsi_pkg::PH_HELD);
                bus.rd_data[rslsi_pkg::ST_PICK0] = st_r.pick0;
                bus.rd_data[rslsi_pkg::ST_PICK1] = st_r.pick1;
                bus.rd_data[rslsi_pkg::ST_CODE_LO +: rslsi_pkg::CODE_W] = st_r.code;
                bus.rd_data[rslsi_pkg::ST_COMPOUND] = st_r.compound;
                bus.rd_data[rslsi_pkg::ST_MASK_LO +: rslsi_pkg::DS_PORTS] = st_r.mask;
                bus.rd_data[rslsi_pkg::ST_HS_LOW] = st_r.hs_low;
                bus.rd_data[rslsi_pkg::ST_SUSP_LOW] = st_r.susp_low;
            end
            rslsi_pkg::REG_CTRL:
            begin
                bus.rd_data[rslsi_pkg::CTRL_W-1:0] = st_r.ctrl;
            end
            rslsi_pkg::REG_EVENT:
            begin
                bus.rd_data[rslsi_pkg::EVT_W-1:0] = st_r.evt;
            end
            rslsi_pkg::REG_PULSE:
            begin
                bus.rd_data[rslsi_pkg::CNT_W-1:0] = st_r.last_low;
            end
            default:
            begin
                bus.rd_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset tracking, strap capture and lamps.

    always_comb
    begin
        st_nxt = st_r;
        evt_set = '0;
        if (wr_ctrl)
        begin
            st_nxt.ctrl = bus.wr_data[rslsi_pkg::CTRL_W-1:0];
        end
        unique case (st_r.phase)
            rslsi_pkg::PH_HELD:
            begin
                if (!hub_reset_n)
                begin
                    // low time measured
                    // The counter saturates so a very long hold cannot wrap to look short.
                    if (st_r.low_cnt != rslsi_pkg::CNT_MAX)
                    begin
                        st_nxt.low_cnt = st_r.low_cnt + 1'b1;
                    end
                end
                else
                begin
                    st_nxt.phase = rslsi_pkg::PH_RUN;
                    st_nxt.valid = 1'b1;
                    st_nxt.last_low = st_r.low_cnt;
                    evt_set[rslsi_pkg::EV_RELEASE] = 1'b1;
                    // short pulse flagged
                    // A glitch is still honoured; software only learns it was too short.
                    evt_set[rslsi_pkg::EV_SHORT] = (st_r.low_cnt != '0)
                        && (st_r.low_cnt < MIN_LOW);
                    st_nxt.pick0 = config_pick_0_in;
                    st_nxt.pick1 = high_speed_lamp_in;
                    st_nxt.code = cap_code;
                    st_nxt.mask = cap_mask;
                    st_nxt.compound = (cap_code != '0);
                    // lamp polarity from strap
                    // A pulled-up strap means the lamp hangs to the supply: drive low for on.
                    st_nxt.hs_low = high_speed_lamp_in;
                    st_nxt.susp_low = suspend_lamp_in;
                end
            end
            rslsi_pkg::PH_RUN:
            begin
                // held until next assertion
                // Pins are ignored until the reset input falls.
                if (!hub_reset_n)
                begin
                    st_nxt.phase = rslsi_pkg::PH_HELD;
                    st_nxt.valid = 1'b0;
                    st_nxt.low_cnt = 16'h0001;
                end
            end
        endcase

        // Set wins over a clear in the same cycle.
        st_nxt.evt = (st_r.evt & ~evt_clr) | evt_set;

        // high-speed and suspend lamp state
        // The lamp releases its pin while held in reset so the strap can be read.
        st_nxt.hs_o = hs_connected ^ st_r.hs_low;
        st_nxt.hs_oe = (st_r.phase == rslsi_pkg::PH_RUN) && st_r.valid
            && st_r.ctrl[rslsi_pkg::CT_HS_EN] && hub_reset_n;
        st_nxt.susp_o = hub_active ^ st_r.susp_low;
        st_nxt.susp_oe = (st_r.phase == rslsi_pkg::PH_RUN) && st_r.valid
            && st_r.ctrl[rslsi_pkg::CT_SUSP_EN] && hub_reset_n;
    end

    // State register.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.phase <= rslsi_pkg::PH_HELD;
            st_r.ctrl <= rslsi_pkg::CTRL_RESET;
            st_r.evt <= rslsi_pkg::EVT_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign high_speed_lamp_out = st_r.hs_o;
    assign high_speed_lamp_oe = st_r.hs_oe;
    assign suspend_lamp_out = st_r.susp_o;
    assign suspend_lamp_oe = st_r.susp_oe;
    assign hub_in_reset = (st_r.phase == rslsi_pkg::PH_HELD);
    assign straps_valid = st_r.valid;
    assign config_method = {st_r.pick1, st_r.pick0};
    assign fixed_port_code = st_r.code;
    assign fixed_port_mask = st_r.mask;
    assign compound_dev = st_r.compound;

endmodule

// File: verif/rslsi_properties.sv
module rslsi_checker (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Strap pins and lamps.
    input wire logic hub_reset_n,
    input wire logic config_pick_0_in,
    input wire logic high_speed_lamp_in,
    input wire logic suspend_lamp_in,
    input wire logic high_speed_lamp_out,
    input wire logic high_speed_lamp_oe,
    input wire logic suspend_lamp_out,
    input wire logic suspend_lamp_oe,
    input wire logic hs_connected,
    input wire logic hub_active,
    // Captured configuration.
    input wire logic hub_in_reset,
    input wire logic straps_valid,
    input wire logic [1:0] config_method,
    input wire logic [rslsi_pkg::CODE_W-1:0] fixed_port_code,
    input wire logic [rslsi_pkg::DS_PORTS-1:0] fixed_port_mask,
    input wire logic compound_dev
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Capture edge: hub reset pin high while held.
    logic cap;
    logic lo_strap_r;
    assign cap = hub_in_reset && hub_reset_n;

    // Keep the low strap: the code reads zero with the strap function off.
    always_ff @(posedge ref_clk)
    begin
        if (nrst && cap)
            lo_strap_r <= suspend_lamp_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_pick0_latch: // first pick
        assert property (cap |=> config_method[0] == $past(config_pick_0_in))
        else $error("pick0 not latched");
    a_pick1_latch: // second pick
        assert property (cap |=> config_method[1] == $past(high_speed_lamp_in))
        else $error("pick1 not latched");
    a_release_valid: // capture done
        assert property (cap |=> straps_valid && !hub_in_reset)
        else $error("straps not valid");
    a_mask_decode: // port mask
        assert property (straps_valid |-> fixed_port_mask == (4'h1 << fixed_port_code) - 4'h1)
        else $error("mask mismatch");
    a_compound_flag: // compound device
        assert property (straps_valid |-> compound_dev == (fixed_port_code != 2'h0))
        else $error("compound mismatch");
    a_hs_lamp: // speed lamp
        assert property (high_speed_lamp_oe |->
            high_speed_lamp_out == ($past(hs_connected) ^ config_method[1]))
        else $error("speed lamp wrong");
    a_susp_lamp: // low strap lamp
        assert property (suspend_lamp_oe |-> suspend_lamp_out == ($past(hub_active) ^ lo_strap_r))
        else $error("suspend lamp wrong");
    a_straps_hold: // held values
        assert property (straps_valid && $past(straps_valid) |->
            $stable(config_method) && $stable(fixed_port_code))
        else $error("straps changed");
    a_lamp_release: // strap pins free
        assert property (!hub_reset_n |=> !high_speed_lamp_oe && !suspend_lamp_oe)
        else $error("lamps driven in reset");
endmodule

bind rslsi_top rslsi_checker rslsi_checker_i (
    .ref_clk, .nrst, .hub_reset_n, .config_pick_0_in, .high_speed_lamp_in, .suspend_lamp_in,
    .high_speed_lamp_out, .high_speed_lamp_oe, .suspend_lamp_out, .suspend_lamp_oe,
    .hs_connected, .hub_active, .hub_in_reset, .straps_valid, .config_method,
    .fixed_port_code, .fixed_port_mask, .compound_dev
);

// File: verif/rslsi_board.sv
module rslsi_board (
    // Clock.
    input wire logic ref_clk,
    // Lamp drive from the hub.
    input wire logic high_speed_lamp_out,
    input wire logic high_speed_lamp_oe,
    input wire logic suspend_lamp_out,
    input wire logic suspend_lamp_oe,
    // Reset and strap pins as the hub sees them.
    output logic hub_reset_n,
    output logic config_pick_0_in,
    output logic fixed_port_strap_hi_in,
    output logic high_speed_lamp_in,
    output logic suspend_lamp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Straps: pick0, pick1, high code bit, low code bit.
    logic [3:0] strap_r = 4'h0;
    logic rst_n_r = 1'b0, pick0_r = 1'b0, hi_r = 1'b0;
    assign hub_reset_n = rst_n_r;
    assign config_pick_0_in = pick0_r;
    assign fixed_port_strap_hi_in = hi_r;
    // Shared lamp pins: hub drive wins, else the strap resistor.
    assign high_speed_lamp_in = high_speed_lamp_oe ? high_speed_lamp_out : strap_r[2];
    assign suspend_lamp_in = suspend_lamp_oe ? suspend_lamp_out : strap_r[0];

    task automatic hold_reset(input logic [3:0] s);
        @(posedge ref_clk);
        rst_n_r <= 1'b0;
        strap_r <= s;
        pick0_r <= s[3];
        hi_r <= s[1];
        repeat (rslsi_pkg::RESET_MIN_CYC) @(posedge ref_clk);
        rst_n_r <= 1'b1;
    endtask

    // Pin noise once the hub runs.
    task automatic jiggle();
        @(posedge ref_clk);
        pick0_r <= ~pick0_r;
        hi_r <= ~hi_r;
    endtask
endmodule

// File: verif/rslsi_tb.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, config_method, fixed_port_code;
    logic [31:0] s_axi_rdata;
    logic hub_reset_n, config_pick_0_in, fixed_port_strap_hi_in;
    logic high_speed_lamp_in, high_speed_lamp_out, high_speed_lamp_oe;
    logic suspend_lamp_in, suspend_lamp_out, suspend_lamp_oe;
    logic hs_connected = 1'b0, hub_active = 1'b0;
    logic hub_in_reset, straps_valid, compound_dev;
    logic [3:0] fixed_port_mask;
    int errors = 0, total_checks = 0, cycles = 0;
    logic [3:0] masks [4] = '{4'h0, 4'h1, 4'h3, 4'h7};

    rslsi_top rslsi_top_i (
        .ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .hub_reset_n, .config_pick_0_in, .fixed_port_strap_hi_in,
        .high_speed_lamp_in, .high_speed_lamp_out, .high_speed_lamp_oe, .suspend_lamp_in,
        .suspend_lamp_out, .suspend_lamp_oe, .hs_connected, .hub_active, .hub_in_reset,
        .straps_valid, .config_method, .fixed_port_code, .fixed_port_mask, .compound_dev
    );
    rslsi_board rslsi_board_i (
        .ref_clk, .high_speed_lamp_out, .high_speed_lamp_oe, .suspend_lamp_out,
        .suspend_lamp_oe, .hub_reset_n, .config_pick_0_in, .fixed_port_strap_hi_in,
        .high_speed_lamp_in, .suspend_lamp_in
    );

    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    // A hung handshake would stall forever, so the run is capped.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Write: both channels offered together, each released once taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge ref_clk);
            if (!aw_done && s_axi_awready)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // All strap patterns, then pin noise after release.
    task automatic t_straps();
        logic [3:0] s;
        logic hs;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 16; i++)
        begin
            s = 4'(i);
            hs = s[0] ^ s[3];
            hs_connected <= hs;
            hub_active <= s[1];
            rslsi_board_i.hold_reset(s);
            repeat (3) @(posedge ref_clk);
            #1;
            chk(32'(config_method), 32'({s[2], s[3]}), "method");
            chk(32'(fixed_port_code), 32'(s[1:0]), "code");
            chk(32'(fixed_port_mask), 32'(masks[s[1:0]]), "mask");
            chk(32'(compound_dev), 32'(s[1:0] != 2'h0), "compound");
            chk(32'(high_speed_lamp_oe), 32'h0000_0001, "lamp drive");
            chk(32'(high_speed_lamp_out), 32'(hs ^ s[2]), "speed lamp");
            chk(32'(suspend_lamp_out), 32'(s[1] ^ s[0]), "suspend lamp");
            axi_read(rslsi_pkg::REG_STATUS, d, r);
            chk(32'(d[6:4]), 32'({s[1:0] != 2'h0, s[1:0]}), "status");
            rslsi_board_i.jiggle();
            repeat (2) @(posedge ref_clk);
            #1;
            chk(32'(config_method), 32'({s[2], s[3]}), "held method");
            chk(32'(fixed_port_code), 32'(s[1:0]), "held code");
        end
    endtask

    // Strap function off: code zero, lamp polarity still from strap.
    task automatic t_fixed_off();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(rslsi_pkg::REG_CTRL, d, r);
        chk(d, 32'(rslsi_pkg::CTRL_RESET), "ctrl reset");
        axi_write(rslsi_pkg::REG_CTRL, 32'h0000_0003, r);
        chk(32'(r), 32'(rslsi_pkg::RESP_OKAY), "ctrl write");
        hub_active <= 1'b1;
        rslsi_board_i.hold_reset(4'b0011);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'(fixed_port_code), 32'h0000_0000, "off code");
        chk(32'(fixed_port_mask), 32'h0000_0000, "off mask");
        chk(32'(compound_dev), 32'h0000_0000, "off compound");
        chk(32'(suspend_lamp_out), 32'h0000_0000, "off lamp");
        axi_read(rslsi_pkg::REG_PULSE, d, r);
        chk(d, 32'(rslsi_pkg::RESET_MIN_CYC), "pulse");
        axi_read(rslsi_pkg::REG_CTRL, d, r);
        chk(d, 32'h0000_0003, "ctrl readback");
        axi_write(rslsi_pkg::REG_CTRL, 32'h0000_0007, r);
        axi_read(8'h10, d, r);
        chk(32'(r), 32'(rslsi_pkg::RESP_SLVERR), "unmapped resp");
        chk(d, 32'h0000_0000, "unmapped data");
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_straps();
        t_fixed_off();
        summarize();
    end
endmodule
